// ==== verilog/adcc_pkg.sv ====
package adcc_pkg;

  // Special-function bus map
  localparam logic [7:0] ADDR_CONTROL = 8'he8;
  localparam logic [7:0] PAGE_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_POWER_UP = 8'hba;
  localparam logic [7:0] PAGE_POWER_UP = 8'h0f;

  // Control register field positions
  localparam int BIT_ENABLE = 7;
  localparam int BIT_BURST = 6;
  localparam int BIT_DONE = 5;
  localparam int BIT_BUSY = 4;
  localparam int BIT_WINDOW = 3;
  localparam int SRC_MSB = 2;
  localparam int SRC_LSB = 0;

  // Power-up time register field positions
  localparam int BIT_LOW_POWER = 7;
  localparam int PWR_MSB = 3;
  localparam int PWR_LSB = 0;

  // Values after reset
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_POWER_UP = 8'h0f;

  // Start-source codes
  localparam logic [2:0] SRC_SOFTWARE = 3'h0;
  localparam logic [2:0] SRC_TIMER0 = 3'h1;
  localparam logic [2:0] SRC_TIMER2 = 3'h2;
  localparam logic [2:0] SRC_TIMER3 = 3'h3;

  // Converter clocks per result
  localparam int CLK_W = 6;
  localparam logic [CLK_W-1:0] CLKS_8BIT = 6'h0b;
  localparam logic [CLK_W-1:0] CLKS_10BIT = 6'h0d;
  localparam logic [CLK_W-1:0] CLKS_12BIT = 6'h34;
  localparam int DIV_W = 5;

  // Burst repeat counts
  localparam int RPT_W = 7;
  localparam logic [RPT_W-1:0] RPT_1 = 7'h01;
  localparam logic [RPT_W-1:0] RPT_4 = 7'h04;
  localparam logic [RPT_W-1:0] RPT_8 = 7'h08;
  localparam logic [RPT_W-1:0] RPT_16 = 7'h10;
  localparam logic [RPT_W-1:0] RPT_32 = 7'h20;
  localparam logic [RPT_W-1:0] RPT_64 = 7'h40;

  // Power-up wait: one unit per step of the power-up field
  localparam int CLK_PERIOD_NS = 25;
  localparam int PWRUP_UNIT_NS = 200;
  localparam int PWRUP_UNIT_CYC = (PWRUP_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PWRUP_W = 8;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_POWER_UP = 2'b01,
    ST_CONVERT = 2'b11
  } adcc_state_e;

endpackage

// ==== verilog/adcc_conv_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface adcc_conv_if;
  logic start;
  logic [adcc_pkg::CLK_W-1:0] clocks;
  logic [adcc_pkg::DIV_W-1:0] div;
  logic done;

  modport ctl (output start, output clocks, output div, input done);
  modport seq (input start, input clocks, input div, output done);
endinterface

`default_nettype wire

// ==== verilog/adcc_conv_seq.sv ====
`timescale 1ns/1ps
`default_nettype none

// Counts converter clocks for one result; the converter clock is the
// system clock divided by div+1.
module adcc_conv_seq (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Sequencer side of the conversion link
  adcc_conv_if.seq bus
);

  logic [adcc_pkg::DIV_W-1:0] div_q;
  logic [adcc_pkg::CLK_W-1:0] left_q;
  logic busy_q;
  logic done_q;

  wire sar_tick = (div_q == '0);
  wire last_clock = (left_q == adcc_pkg::CLK_W'(1));

  assign bus.done = done_q;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      div_q <= '0;
      left_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (bus.start)
      begin
        busy_q <= 1'b1;
        left_q <= bus.clocks;
        div_q <= bus.div;
      end
      else if (busy_q)
      begin
        if (sar_tick)
        begin
          div_q <= bus.div;
          left_q <= left_q - adcc_pkg::CLK_W'(1);
          if (last_clock)
          begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end
        end
        else
        begin
          div_q <= div_q - adcc_pkg::DIV_W'(1);
        end
      end
    end
  end

endmodule

`default_nettype wire

// ==== verilog/adcc_control.sv ====
// Function
// - Low power bit selects reduced bias
// - Eleven, thirteen or fifty-two converter clocks
// - Enable bit seven: shutdown or ready
// - Bit six selects burst or single
// - Done flag after conversion or burst
// - Done flag held until software clears
// - Busy write starts only in software mode
// - Window hit flag when result in window
// - Codes one to three pick timers
// - Top code bit picks external rising edge
// - Source field bits two to zero
// - Control at e8, bit-addressable, reset zero
// - Burst runs repeat count per start
// - Burst without enable powers up first
// - Window compare waits for whole burst
`timescale 1ns/1ps
`default_nettype none

module adcc_control (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Special-function bus
  input wire logic [7:0] i_sfr_page,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_sfr_bit_wr,
  input wire logic [7:0] i_sfr_bit_addr,
  input wire logic i_sfr_bit_val,
  output logic [7:0] o_sfr_rdata,
  // Settings held in neighbouring registers
  input wire logic i_eight_bit,
  input wire logic i_twelve_bit,
  input wire logic [2:0] i_repeat_code,
  input wire logic [4:0] i_sar_div,
  // Start sources
  input wire logic i_timer0_ovf,
  input wire logic i_timer2_ovf,
  input wire logic i_timer3_ovf,
  input wire logic i_external_start_pin,
  // Result and window bounds
  input wire logic [15:0] i_result,
  input wire logic [15:0] i_greater_than,
  input wire logic [15:0] i_less_than,
  // Converter and status
  output logic o_converter_power,
  output logic o_low_power_bias,
  output logic o_conv_active,
  output logic o_sample_done,
  output logic o_conversion_done_flag,
  output logic o_window_hit_flag
);

  adcc_conv_if conv ();

  adcc_conv_seq u_seq (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .bus(conv.seq)
  );

  // External start pin: two-stage synchroniser, then edge detect
  logic ext_meta_q;
  logic ext_sync_q;
  logic ext_prev_q;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end
    else
    begin
      ext_meta_q <= i_external_start_pin;
      ext_sync_q <= ext_meta_q;
      ext_prev_q <= ext_sync_q;
    end
  end

  // A start is seen three clocks after the pin rises; a pin pulse
  // shorter than one clock may be missed
  wire ext_rise = ext_sync_q & ~ext_prev_q;

  // Register decode
  logic [7:0] ctl_q;
  logic [7:0] pwr_q;
  logic done_q;
  logic win_q;
  adcc_pkg::adcc_state_e state_q;

  wire ctl_page = (i_sfr_page == adcc_pkg::PAGE_CONTROL);
  wire ctl_byte_wr = i_sfr_wr & ctl_page & (i_sfr_addr == adcc_pkg::ADDR_CONTROL);
  wire ctl_bit_wr = i_sfr_bit_wr & ctl_page
    & (i_sfr_bit_addr[7:3] == adcc_pkg::ADDR_CONTROL[7:3]);
  wire pwr_wr = i_sfr_wr & (i_sfr_page == adcc_pkg::PAGE_POWER_UP)
    & (i_sfr_addr == adcc_pkg::ADDR_POWER_UP);
  wire [7:0] bit_mask = 8'h01 << i_sfr_bit_addr[2:0];
  wire [7:0] wr_mask = ctl_byte_wr ? 8'hff : (ctl_bit_wr ? bit_mask : 8'h00);
  wire [7:0] wr_data = ctl_byte_wr ? i_sfr_wdata : {8{i_sfr_bit_val}};

  // Only enable, burst and source bits are plain storage
  wire [7:0] plain_mask = 8'hc7;
  wire [7:0] ctl_d = ((ctl_q & ~wr_mask) | (wr_data & wr_mask)) & plain_mask;

  wire conv_enable = ctl_q[adcc_pkg::BIT_ENABLE];
  wire burst_mode_on = ctl_q[adcc_pkg::BIT_BURST];
  wire [2:0] start_source_select = ctl_q[adcc_pkg::SRC_MSB:adcc_pkg::SRC_LSB];

  wire done_clear = wr_mask[adcc_pkg::BIT_DONE] & ~wr_data[adcc_pkg::BIT_DONE];
  wire win_clear = wr_mask[adcc_pkg::BIT_WINDOW] & ~wr_data[adcc_pkg::BIT_WINDOW];

  // Start-source selection; the stored source field decides, so a byte
  // write that changes the source to software and sets busy together starts nothing
  wire sw_start = wr_mask[adcc_pkg::BIT_BUSY] & wr_data[adcc_pkg::BIT_BUSY]
    & (start_source_select == adcc_pkg::SRC_SOFTWARE);
  wire timer_start =
    ((start_source_select == adcc_pkg::SRC_TIMER0) & i_timer0_ovf)
    | ((start_source_select == adcc_pkg::SRC_TIMER2) & i_timer2_ovf)
    | ((start_source_select == adcc_pkg::SRC_TIMER3) & i_timer3_ovf);
  wire trigger = start_source_select[2] ? ext_rise : (sw_start | timer_start);

  // Starts arriving mid-burst are dropped; software keeps them spaced
  wire idle = (state_q == adcc_pkg::ST_IDLE);
  wire start_ok = trigger & idle & (conv_enable | burst_mode_on);

  // Repeat count decode; reserved codes fall back to one
  wire [adcc_pkg::RPT_W-1:0] repeat_total =
    (i_repeat_code == 3'h1) ? adcc_pkg::RPT_4 :
    (i_repeat_code == 3'h2) ? adcc_pkg::RPT_8 :
    (i_repeat_code == 3'h3) ? adcc_pkg::RPT_16 :
    (i_repeat_code == 3'h4) ? adcc_pkg::RPT_32 :
    (i_repeat_code == 3'h5) ? adcc_pkg::RPT_64 : adcc_pkg::RPT_1;
  wire [adcc_pkg::RPT_W-1:0] run_total = burst_mode_on ? repeat_total : adcc_pkg::RPT_1;

  // Converter clocks per result
  assign conv.clocks = i_twelve_bit ? adcc_pkg::CLKS_12BIT :
    (i_eight_bit ? adcc_pkg::CLKS_8BIT : adcc_pkg::CLKS_10BIT);
  assign conv.div = i_sar_div;

  // Power-up wait from the power-up time field, in whole system clocks
  // rounded up, so a slower clock only lengthens the wait
  wire [4:0] pwr_steps = {1'b0, pwr_q[adcc_pkg::PWR_MSB:adcc_pkg::PWR_LSB]} + 5'h01;
  wire [adcc_pkg::PWRUP_W-1:0] pwr_wait =
    adcc_pkg::PWRUP_W'(pwr_steps * adcc_pkg::PWRUP_UNIT_CYC) - adcc_pkg::PWRUP_W'(1);

  // Window test; a reversed pair of bounds selects the outside region
  wire bounds_normal = (i_less_than > i_greater_than);
  wire above_gt = (i_result > i_greater_than);
  wire below_lt = (i_result < i_less_than);
  wire in_window = bounds_normal ? (above_gt & below_lt) : (above_gt | below_lt);

  // Sequencing
  logic [adcc_pkg::RPT_W-1:0] left_q;
  logic [adcc_pkg::PWRUP_W-1:0] wait_q;
  logic conv_start_q;
  logic run_end;
  adcc_pkg::adcc_state_e state_d;

  assign conv.start = conv_start_q;

  wire last_result = (left_q == adcc_pkg::RPT_W'(1));
  wire wait_over = (wait_q == '0);

  always_comb
  begin
    state_d = state_q;
    run_end = 1'b0;
    unique case (state_q)
      adcc_pkg::ST_IDLE:
      begin
        if (start_ok)
        begin
          if (burst_mode_on & ~conv_enable)
          begin
            state_d = adcc_pkg::ST_POWER_UP;
          end
          else
          begin
            state_d = adcc_pkg::ST_CONVERT;
          end
        end
      end
      adcc_pkg::ST_POWER_UP:
      begin
        if (wait_over)
        begin
          state_d = adcc_pkg::ST_CONVERT;
        end
      end
      adcc_pkg::ST_CONVERT:
      begin
        if (conv.done & last_result)
        begin
          state_d = adcc_pkg::ST_IDLE;
          run_end = 1'b1;
        end
      end
      default:
      begin
        state_d = adcc_pkg::ST_IDLE;
      end
    endcase
  end

  wire go_convert = (start_ok & ~(burst_mode_on & ~conv_enable))
    | ((state_q == adcc_pkg::ST_POWER_UP) & wait_over);
  wire next_in_burst = (state_q == adcc_pkg::ST_CONVERT) & conv.done & ~last_result;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_q <= adcc_pkg::ST_IDLE;
      left_q <= '0;
      wait_q <= '0;
      conv_start_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      conv_start_q <= go_convert | next_in_burst;
      if (start_ok)
      begin
        left_q <= run_total;
        wait_q <= pwr_wait;
      end
      else if (next_in_burst)
      begin
        left_q <= left_q - adcc_pkg::RPT_W'(1);
      end
      else if ((state_q == adcc_pkg::ST_POWER_UP) & ~wait_over)
      begin
        wait_q <= wait_q - adcc_pkg::PWRUP_W'(1);
      end
    end
  end

  // Registers; a hardware set wins over a clear in the same cycle
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ctl_q <= adcc_pkg::RST_CONTROL;
      pwr_q <= adcc_pkg::RST_POWER_UP;
      done_q <= 1'b0;
      win_q <= 1'b0;
    end
    else
    begin
      ctl_q <= ctl_d;
      if (pwr_wr)
      begin
        pwr_q <= i_sfr_wdata & 8'h8f;
      end
      done_q <= run_end | (done_q & ~done_clear);
      win_q <= (run_end & in_window) | (win_q & ~win_clear);
    end
  end

  // Read data and outputs
  wire [7:0] ctl_read = {conv_enable, burst_mode_on, done_q, ~idle, win_q,
    start_source_select};
  wire [7:0] rdata_d = (ctl_page & (i_sfr_addr == adcc_pkg::ADDR_CONTROL)) ? ctl_read :
    (((i_sfr_page == adcc_pkg::PAGE_POWER_UP) & (i_sfr_addr == adcc_pkg::ADDR_POWER_UP))
    ? pwr_q : 8'h00);

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_sfr_rdata <= 8'h00;
      o_converter_power <= 1'b0;
      o_low_power_bias <= 1'b0;
      o_conv_active <= 1'b0;
      o_sample_done <= 1'b0;
      o_conversion_done_flag <= 1'b0;
      o_window_hit_flag <= 1'b0;
    end
    else
    begin
      o_sfr_rdata <= rdata_d;
      o_converter_power <= conv_enable | (state_d != adcc_pkg::ST_IDLE);
      o_low_power_bias <= pwr_q[adcc_pkg::BIT_LOW_POWER];
      o_conv_active <= (state_d == adcc_pkg::ST_CONVERT);
      o_sample_done <= conv.done;
      o_conversion_done_flag <= run_end | (done_q & ~done_clear);
      o_window_hit_flag <= (run_end & in_window) | (win_q & ~win_clear);
    end
  end

endmodule

`default_nettype wire

// ==== test/adcc_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module adcc_assertions (
  // Bus side
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_sfr_page,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_sfr_bit_wr,
  input wire logic [7:0] i_sfr_bit_addr,
  input wire logic i_sfr_bit_val,
  input wire logic [7:0] o_sfr_rdata,
  // Converter side
  input wire logic o_converter_power,
  input wire logic o_low_power_bias,
  input wire logic o_conv_active,
  input wire logic o_sample_done,
  input wire logic o_conversion_done_flag,
  input wire logic o_window_hit_flag
);
  logic [3:0] sd_q;
  wire pg0 = i_sfr_page == 8'h00;
  wire ctl_wr = i_sfr_wr && pg0 && i_sfr_addr == 8'he8;
  wire pwr_sel = i_sfr_page == 8'h0f && i_sfr_addr == 8'hba;
  wire bit_clr = i_sfr_bit_wr && pg0 && !i_sfr_bit_val;
  wire clr_done = (ctl_wr && !i_sfr_wdata[5]) || (bit_clr && i_sfr_bit_addr == 8'hed);
  wire clr_win = (ctl_wr && !i_sfr_wdata[3]) || (bit_clr && i_sfr_bit_addr == 8'heb);
  wire mapped = (pg0 && i_sfr_addr == 8'he8) || pwr_sel;
  wire recent = |sd_q || o_sample_done;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  // Flags may lag the last result by a few edges
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      sd_q <= 4'h0;
    else
      sd_q <= {sd_q[2:0], o_sample_done};
  end

  sequence s_enable_write;
    ctl_wr && i_sfr_wdata[7];
  endsequence

  a_bias_follows: assert property (i_sfr_wr && pwr_sel |-> ##2 o_low_power_bias == $past(i_sfr_wdata[7], 2))
    else $error("bias mismatch");
  a_enable_powers: assert property (s_enable_write |-> ##2 o_converter_power)
    else $error("enable without power");
  a_done_sticky: assert property ($fell(o_conversion_done_flag) |-> $past(clr_done) || $past(clr_done, 2))
    else $error("done flag lost");
  a_window_sticky: assert property ($fell(o_window_hit_flag) |-> $past(clr_win) || $past(clr_win, 2))
    else $error("window flag lost");
  a_done_cause: assert property ($rose(o_conversion_done_flag) |-> recent)
    else $error("done without result");
  a_window_cause: assert property ($rose(o_window_hit_flag) |-> recent)
    else $error("window without result");
  a_active_powered: assert property (o_conv_active |-> o_converter_power)
    else $error("convert while off");
  a_sample_pulse: assert property (o_sample_done |=> !o_sample_done)
    else $error("result pulse too long");
  a_unmapped_zero: assert property (!mapped |=> o_sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule

bind adcc_control adcc_assertions u_chk (.i_clk, .i_rst, .i_sfr_page, .i_sfr_addr, .i_sfr_wr,
  .i_sfr_wdata, .i_sfr_bit_wr, .i_sfr_bit_addr, .i_sfr_bit_val, .o_sfr_rdata, .o_converter_power,
  .o_low_power_bias, .o_conv_active, .o_sample_done, .o_conversion_done_flag, .o_window_hit_flag);
`default_nettype wire

// ==== test/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {logic [7:0] p; logic [7:0] a; logic [7:0] d; logic [7:0] e; logic b;} adcc_row_s;
  logic i_clk, i_rst, i_sfr_wr, i_sfr_bit_wr, i_sfr_bit_val, i_eight_bit, i_twelve_bit;
  logic [7:0] i_sfr_page, i_sfr_addr, i_sfr_wdata, i_sfr_bit_addr, o_sfr_rdata, rv;
  logic [2:0] i_repeat_code;
  logic [4:0] i_sar_div;
  logic [3:0] trig;
  logic [15:0] i_result, i_greater_than, i_less_than;
  logic o_converter_power, o_low_power_bias, o_conv_active, o_sample_done, o_done, o_win;
  int errors, comparisons, cycles, n, f, k, s, e;
  int t[3];
  int rep[7] = '{1, 4, 8, 16, 32, 64, 1};
  adcc_row_s rows [6] = '{{8'h0f, 8'hba, 8'hff, 8'h8f, 1'b1}, {8'h0f, 8'hba, 8'h05, 8'h05, 1'b0},
    {8'h00, 8'he8, 8'hff, 8'hc7, 1'b0}, {8'h00, 8'he8, 8'h00, 8'h00, 1'b0},
    {8'h00, 8'hba, 8'h33, 8'h00, 1'b0}, {8'h00, 8'h12, 8'haa, 8'h00, 1'b0}};

  adcc_control dut_u (.i_clk, .i_rst, .i_sfr_page, .i_sfr_addr, .i_sfr_wr, .i_sfr_wdata,
    .i_sfr_bit_wr, .i_sfr_bit_addr, .i_sfr_bit_val, .o_sfr_rdata, .i_eight_bit, .i_twelve_bit,
    .i_repeat_code, .i_sar_div, .i_timer0_ovf(trig[0]), .i_timer2_ovf(trig[1]),
    .i_timer3_ovf(trig[2]), .i_external_start_pin(trig[3]), .i_result, .i_greater_than,
    .i_less_than, .o_converter_power, .o_low_power_bias, .o_conv_active, .o_sample_done,
    .o_conversion_done_flag(o_done), .o_window_hit_flag(o_win));

  always #12.5 i_clk = ~i_clk;

  task stop_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Ceiling well above the longest burst sequence
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      errors++;
      stop_test();
    end
  end

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task wr(input logic [7:0] p, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_sfr_page <= p;
    i_sfr_addr <= a;
    i_sfr_wdata <= d;
    i_sfr_wr <= 1'b1;
    @(posedge i_clk);
    i_sfr_wr <= 1'b0;
  endtask

  task rd(input logic [7:0] p, input logic [7:0] a);
    @(posedge i_clk);
    i_sfr_page <= p;
    i_sfr_addr <= a;
    @(posedge i_clk);
    @(negedge i_clk);
    rv = o_sfr_rdata;
  endtask

  task bw(input logic [7:0] a, input logic v);
    @(posedge i_clk);
    i_sfr_page <= 8'h00;
    i_sfr_bit_addr <= a;
    i_sfr_bit_val <= v;
    i_sfr_bit_wr <= 1'b1;
    @(posedge i_clk);
    i_sfr_bit_wr <= 1'b0;
  endtask

  task fire(input int i);
    @(posedge i_clk);
    trig[i] <= 1'b1;
    @(posedge i_clk);
    trig[i] <= 1'b0;
  endtask

  // Counts results and the wait to the first one
  task wait_done;
    n = 0;
    f = 0;
    e = 0;
    for (int i = 1; i < 8000 && o_done !== 1'b1; i++)
    begin
      @(negedge i_clk);
      if (n == 0) f = i;
      n += int'(o_sample_done === 1'b1);
      e |= int'(o_win === 1'b1 && o_done !== 1'b1);
    end
    chk(o_done, 1'b1);
  endtask

  task go;
    bw(8'hec, 1'b1);
    wait_done();
  endtask

  initial
  begin
    {i_clk, i_sfr_wr, i_sfr_bit_wr, i_sfr_bit_val, i_eight_bit, i_twelve_bit} = '0;
    {i_sfr_page, i_sfr_addr, i_sfr_wdata, i_sfr_bit_addr, i_repeat_code, i_sar_div, trig} = '0;
    {i_result, i_greater_than, i_less_than} = '0;
    i_rst = 1'b1;
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(8'h00, 8'he8);
    chk(rv, 8'h00);
    rd(8'h0f, 8'hba);
    chk(rv, 8'h0f);
    chk(o_converter_power, 1'b0);
    $display("reset test done");
    foreach (rows[j])
    begin
      wr(rows[j].p, rows[j].a, rows[j].d);
      rd(rows[j].p, rows[j].a);
      chk(rv, rows[j].e);
      chk(o_low_power_bias, rows[j].b);
    end
    $display("register test done");
    for (k = 0; k < 2; k++)
    begin
      wr(8'h00, 8'he8, (k == 1) ? 8'h10 : 8'h91);
      repeat (30) @(negedge i_clk);
      chk({o_conv_active, o_done}, 2'b00);
    end
    $display("refusal test done");
    for (k = 0; k < 3; k++)
    begin
      @(posedge i_clk);
      i_sar_div <= 5'h01;
      i_eight_bit <= (k == 0);
      i_twelve_bit <= (k == 2);
      wr(8'h00, 8'he8, 8'h80);
      go();
      t[k] = f;
      repeat (20) @(negedge i_clk);
      chk(o_done, 1'b1);
      bw(8'hed, 1'b0);
      rd(8'h00, 8'he8);
      chk(rv, 8'h80);
    end
    chk(16'(t[1] - t[0]), 16'h0004);
    chk(16'(t[2] - t[1]), 16'h004e);
    $display("resolution test done");
    @(posedge i_clk);
    i_sar_div <= 5'h00;
    i_twelve_bit <= 1'b0;
    for (k = 1; k < 8; k++)
    begin
      s = (k > 3) ? 3 : k - 1;
      wr(8'h00, 8'he8, 8'h80 | 8'(k));
      fire((s + 1) % 4);
      repeat (30) @(negedge i_clk);
      chk(o_done, 1'b0);
      fire(s);
      wait_done();
      chk(16'(n), 16'h0001);
      wr(8'h00, 8'he8, 8'h80);
    end
    $display("source test done");
    wr(8'h0f, 8'hba, 8'h03);
    for (k = 0; k < 7; k++)
    begin
      @(posedge i_clk);
      i_repeat_code <= 3'(k);
      wr(8'h00, 8'he8, 8'h40);
      go();
      chk(16'(n), 16'(rep[k]));
      chk(16'(f >= 43), 16'h0001);
      repeat (5) @(negedge i_clk);
      chk(o_converter_power, 1'b0);
      wr(8'h00, 8'he8, 8'h40);
    end
    $display("burst test done");
    @(posedge i_clk);
    i_repeat_code <= 3'h1;
    for (k = 0; k < 4; k++)
    begin
      @(posedge i_clk);
      i_result <= (k == 1 || k == 3) ? 16'h0200 : 16'h0050;
      {i_greater_than, i_less_than} <= (k > 1) ? {16'h0100, 16'h0010} : {16'h0010, 16'h0100};
      wr(8'h00, 8'he8, (k == 3) ? 8'hc0 : 8'h80);
      go();
      chk(16'(e), 16'h0000);
      chk(16'(n), (k == 3) ? 16'h0004 : 16'h0001);
      repeat (3) @(negedge i_clk);
      chk(o_win, k == 0 || k == 3);
      wr(8'h00, 8'he8, 8'h80);
    end
    $display("window test done");
    wr(8'h00, 8'he8, 8'hc0);
    bw(8'hec, 1'b1);
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(8'h00, 8'he8);
    chk(rv, 8'h00);
    chk({o_converter_power, o_conv_active, o_done}, 3'h0);
    $display("mid-run reset test done");
    stop_test();
  end
endmodule
`default_nettype wire
